/* File: logic/dsom_mapper.sv */
// Status output mapper: open-collector output and changeover alarm relay.
// Assumes status inputs are synchronous to clk; settings held stable by software.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Two outputs, open-collector and relay, each pick a status by their own selector.
// - Codes 00 to 06 map to running, constant speed, overreach, overload, deviation, alarm, reached.
// - Codes 09, 11, 12, 13, 21 map to undervoltage, run time, power time, thermal, zero freq.
// - Codes 27, 31, 32, 33 map to analog lost, feedback compare, comm lost, logic result.
// - Codes 41 to 43 and 50 to 54 map to start contact through window compare.
// - Codes 58, 59, 60 map to sources and second motor, and no leaves the output inactive.
// - The open-collector polarity 00 is normally open and 01 normally closed.
// - The relay has its own polarity with the same encoding.
// - Normally open closes the output while the condition is asserted.
// - Normally closed opens the output while the condition is asserted.
// - Relay pair a closes on error under 00, pair b is its opposite, 01 swaps both.
// - A rising condition reaches the output only after the on-delay of up to 100 s.
// - A falling condition reaches the output only after the off-delay, holding it active.
// - With both delays zero the output follows the condition at once.
module dsom_mapper #(
    parameter int TICK_LEN = dsom_pkg::TICK_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     clk_en,
    input  wire logic                     motor_running,
    input  wire logic                     speed_constant_reached,
    input  wire logic                     freq_overreached,
    input  wire logic                     overload_advance_warn,
    input  wire logic                     loop_output_deviation,
    input  wire logic                     alarm_flag,
    input  wire logic                     freq_setpoint_reached,
    input  wire logic                     undervoltage_flag,
    input  wire logic                     run_time_exceeded,
    input  wire logic                     power_time_exceeded,
    input  wire logic                     thermal_alarm,
    input  wire logic                     zero_freq_detect,
    input  wire logic                     analog_input_lost,
    input  wire logic                     feedback_compare,
    input  wire logic                     comm_line_lost,
    input  wire logic                     logic_op_result,
    input  wire logic                     start_contact,
    input  wire logic                     heatsink_overheat_warn,
    input  wire logic                     low_current_flag,
    input  wire logic                     drive_ready_flag,
    input  wire logic                     rotating_forward,
    input  wire logic                     rotating_reverse,
    input  wire logic                     major_failure,
    input  wire logic                     analog_window_compare,
    input  wire logic                     freq_cmd_source,
    input  wire logic                     run_cmd_source,
    input  wire logic                     second_motor_selected,
    input  wire logic [7:0]               oc_output_func_sel,
    input  wire logic [7:0]               relay_output_func_sel,
    input  wire logic [1:0]               oc_output_polarity,
    input  wire logic [1:0]               relay_output_polarity,
    input  wire logic [dsom_pkg::DELAY_W-1:0] oc_output_on_delay,
    input  wire logic [dsom_pkg::DELAY_W-1:0] oc_output_off_delay,
    input  wire logic [dsom_pkg::DELAY_W-1:0] relay_output_on_delay,
    input  wire logic [dsom_pkg::DELAY_W-1:0] relay_output_off_delay,
    output logic                          oc_output_closed,
    output logic                          relay_contact_a,
    output logic                          relay_contact_b,
    output logic                          oc_active,
    output logic                          relay_active
);
    import dsom_pkg::*;

    // ----------------------------------------
    // Condition selection
    // ----------------------------------------
    function automatic logic pick(input logic [7:0] sel);
        logic v;
        v = 1'b0;
        case (sel)
            SEL_RUNNING:     v = motor_running;
            SEL_SPEED_CONST: v = speed_constant_reached;
            SEL_FREQ_OVER:   v = freq_overreached;
            SEL_OVERLOAD:    v = overload_advance_warn;
            SEL_LOOP_DEV:    v = loop_output_deviation;
            SEL_ALARM:       v = alarm_flag;
            SEL_FREQ_SET:    v = freq_setpoint_reached;
            SEL_UNDERVOLT:   v = undervoltage_flag;
            SEL_RUN_TIME:    v = run_time_exceeded;
            SEL_POWER_TIME:  v = power_time_exceeded;
            SEL_THERMAL:     v = thermal_alarm;
            SEL_ZERO_FREQ:   v = zero_freq_detect;
            SEL_ANALOG_LOST: v = analog_input_lost;
            SEL_FB_COMPARE:  v = feedback_compare;
            SEL_COMM_LOST:   v = comm_line_lost;
            SEL_LOGIC_OP:    v = logic_op_result;
            SEL_START_CONT:  v = start_contact;
            SEL_HEATSINK:    v = heatsink_overheat_warn;
            SEL_LOW_CURRENT: v = low_current_flag;
            SEL_READY:       v = drive_ready_flag;
            SEL_FORWARD:     v = rotating_forward;
            SEL_REVERSE:     v = rotating_reverse;
            SEL_MAJOR_FAIL:  v = major_failure;
            SEL_WINDOW_CMP:  v = analog_window_compare;
            SEL_FREQ_SOURCE: v = freq_cmd_source;
            SEL_RUN_SOURCE:  v = run_cmd_source;
            SEL_MOTOR2:      v = second_motor_selected;
            default:         v = 1'b0;
        endcase
        return v;
    endfunction : pick

    logic oc_cond;
    logic relay_cond;
    // A plain assign would miss status changes read inside the function
    always_comb begin
        oc_cond    = pick(oc_output_func_sel);
        relay_cond = pick(relay_output_func_sel);
    end

    // ----------------------------------------
    // 0.1 s tick
    // ----------------------------------------
    logic [23:0] tick_cnt_ff;
    logic [23:0] nxt_tick_cnt;
    logic        tick_ff;
    logic        nxt_tick;

    always_comb begin
        nxt_tick     = 1'b0;
        nxt_tick_cnt = tick_cnt_ff + 24'h000001;
        if (tick_cnt_ff >= 24'(TICK_LEN - 1)) begin
            nxt_tick_cnt = 24'h000000;
            nxt_tick     = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_ff <= 24'h000000;
            tick_ff     <= 1'b0;
        end else if (clk_en) begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff     <= nxt_tick;
        end
    end

    // ----------------------------------------
    // Delay filters, one per output
    // ----------------------------------------
    logic [1:0]         cond;
    logic [1:0][9:0]    on_dly;
    logic [1:0][9:0]    off_dly;
    logic [1:0]         act_ff;
    logic [1:0]         nxt_act;
    logic [1:0][9:0]    cnt_ff;
    logic [1:0][9:0]    nxt_cnt;

    assign cond    = {relay_cond, oc_cond};
    assign on_dly  = {relay_output_on_delay, oc_output_on_delay};
    assign off_dly = {relay_output_off_delay, oc_output_off_delay};

    always_comb begin
        logic [9:0] lim;
        lim = DELAY_RST;
        for (int i = 0; i < 2; i++) begin
            nxt_act[i] = act_ff[i];
            nxt_cnt[i] = cnt_ff[i];
            lim = act_ff[i] ? off_dly[i] : on_dly[i];
            if (lim > DELAY_MAX) begin
                lim = DELAY_MAX;
            end
            if (cond[i] == act_ff[i]) begin
                // Pulse ended early: restart so it never shows
                nxt_cnt[i] = DELAY_RST;
            end else if (lim == DELAY_RST) begin
                nxt_act[i] = cond[i];
                nxt_cnt[i] = DELAY_RST;
            end else if (tick_ff) begin
                if (cnt_ff[i] + 10'h001 >= lim) begin
                    nxt_act[i] = cond[i];
                    nxt_cnt[i] = DELAY_RST;
                end else begin
                    nxt_cnt[i] = cnt_ff[i] + 10'h001;
                end
            end
        end
    end

    // ----------------------------------------
    // Polarity and contacts
    // ----------------------------------------
    logic nxt_oc_closed;
    logic nxt_relay_a;

    always_comb begin
        // Normally open closes when active, normally closed opens
        nxt_oc_closed = nxt_act[0];
        if (oc_output_polarity == POL_NORM_CLOSED) begin
            nxt_oc_closed = !nxt_act[0];
        end
        nxt_relay_a = nxt_act[1];
        if (relay_output_polarity == POL_NORM_CLOSED) begin
            nxt_relay_a = !nxt_act[1];
        end
    end

    // Reset mimics power off: pair a open, pair b closed
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            act_ff           <= 2'h0;
            cnt_ff           <= '0;
            oc_output_closed <= 1'b0;
            relay_contact_a  <= 1'b0;
            relay_contact_b  <= 1'b1;
            oc_active        <= 1'b0;
            relay_active     <= 1'b0;
        end else if (clk_en) begin
            act_ff           <= nxt_act;
            cnt_ff           <= nxt_cnt;
            oc_output_closed <= nxt_oc_closed;
            relay_contact_a  <= nxt_relay_a;
            relay_contact_b  <= !nxt_relay_a;
            oc_active        <= nxt_act[0];
            relay_active     <= nxt_act[1];
        end
    end
endmodule : dsom_mapper

`default_nettype wire

/* File: logic/dsom_pkg.sv */
// Constants for the drive status output mapper.
// Assumes a 20 MHz controller clock and delays given in 0.1 s steps.
package dsom_pkg;
    // ----------------------------------------
    // Function selection codes (BCD pairs)
    // ----------------------------------------
    localparam logic [7:0] SEL_RUNNING      = 8'h00;
    localparam logic [7:0] SEL_SPEED_CONST  = 8'h01;
    localparam logic [7:0] SEL_FREQ_OVER    = 8'h02;
    localparam logic [7:0] SEL_OVERLOAD     = 8'h03;
    localparam logic [7:0] SEL_LOOP_DEV     = 8'h04;
    localparam logic [7:0] SEL_ALARM        = 8'h05;
    localparam logic [7:0] SEL_FREQ_SET     = 8'h06;
    localparam logic [7:0] SEL_UNDERVOLT    = 8'h09;
    localparam logic [7:0] SEL_RUN_TIME     = 8'h11;
    localparam logic [7:0] SEL_POWER_TIME   = 8'h12;
    localparam logic [7:0] SEL_THERMAL      = 8'h13;
    localparam logic [7:0] SEL_ZERO_FREQ    = 8'h21;
    localparam logic [7:0] SEL_ANALOG_LOST  = 8'h27;
    localparam logic [7:0] SEL_FB_COMPARE   = 8'h31;
    localparam logic [7:0] SEL_COMM_LOST    = 8'h32;
    localparam logic [7:0] SEL_LOGIC_OP     = 8'h33;
    localparam logic [7:0] SEL_START_CONT   = 8'h41;
    localparam logic [7:0] SEL_HEATSINK     = 8'h42;
    localparam logic [7:0] SEL_LOW_CURRENT  = 8'h43;
    localparam logic [7:0] SEL_READY        = 8'h50;
    localparam logic [7:0] SEL_FORWARD      = 8'h51;
    localparam logic [7:0] SEL_REVERSE      = 8'h52;
    localparam logic [7:0] SEL_MAJOR_FAIL   = 8'h53;
    localparam logic [7:0] SEL_WINDOW_CMP   = 8'h54;
    localparam logic [7:0] SEL_FREQ_SOURCE  = 8'h58;
    localparam logic [7:0] SEL_RUN_SOURCE   = 8'h59;
    localparam logic [7:0] SEL_MOTOR2       = 8'h60;
    localparam logic [7:0] SEL_NONE         = 8'hFF;

    // ----------------------------------------
    // Polarity encodings
    // ----------------------------------------
    localparam logic [1:0] POL_NORM_OPEN    = 2'h0;
    localparam logic [1:0] POL_NORM_CLOSED  = 2'h1;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int         CLK_HZ           = 20_000_000;
    localparam int         TICK_MS          = 100;
    localparam int         TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
    localparam int         DELAY_W          = 10;
    localparam logic [9:0] DELAY_MAX        = 10'h3E8;
    localparam logic [9:0] DELAY_RST        = 10'h000;
endpackage : dsom_pkg

/* File: sim/dsom_checker.sv */
// Port-level checks for the status output mapper.
// Assumes binding onto dsom_mapper with the same TICK_LEN.
`timescale 1ns/1ps
`default_nettype none
module dsom_checker
    import dsom_pkg::*;
#(
    parameter int TICK_LEN = 4
) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       clk_en,
    input wire logic       motor_running,
    input wire logic       alarm_flag,
    input wire logic [7:0] oc_output_func_sel,
    input wire logic [7:0] relay_output_func_sel,
    input wire logic [1:0] oc_output_polarity,
    input wire logic [1:0] relay_output_polarity,
    input wire logic [9:0] oc_output_on_delay,
    input wire logic [9:0] oc_output_off_delay,
    input wire logic [9:0] relay_output_on_delay,
    input wire logic       oc_output_closed,
    input wire logic       relay_contact_a,
    input wire logic       relay_contact_b,
    input wire logic       oc_active,
    input wire logic       relay_active
);
    // A two-tick delay takes TICK_LEN+1 to 2*TICK_LEN cycles by tick phase; the bound adds one spare
    localparam int RISE_MAX = 2 * TICK_LEN + 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_pair; relay_contact_b == !relay_contact_a; endproperty
    a_pair: assert property (p_pair) else $error("pair b not inverse of a");
    property p_oc_pol; clk_en |=> oc_output_closed ==
        (oc_active ^ ($past(oc_output_polarity) == POL_NORM_CLOSED)); endproperty
    a_oc_pol: assert property (p_oc_pol) else $error("oc pol bad");
    property p_ry_pol; clk_en |=> relay_contact_a ==
        (relay_active ^ ($past(relay_output_polarity) == POL_NORM_CLOSED)); endproperty
    a_ry_pol: assert property (p_ry_pol) else $error("relay polarity wrong");
    property p_zero; clk_en && oc_output_func_sel == SEL_RUNNING && oc_output_on_delay == 10'h000
        && oc_output_off_delay == 10'h000 |=> oc_active == $past(motor_running); endproperty
    a_zero: assert property (p_zero) else $error("zero delay not immediate");
    property p_on_hold; clk_en && oc_output_func_sel == SEL_RUNNING && !oc_active
        && oc_output_on_delay > 10'h002 && $rose(motor_running) |=> !oc_active [*3]; endproperty
    a_on_hold: assert property (p_on_hold) else $error("on delay too short");
    property p_off_hold; clk_en && oc_output_func_sel == SEL_RUNNING && oc_active
        && oc_output_off_delay > 10'h002 && $fell(motor_running) |=> oc_active [*3]; endproperty
    a_off_hold: assert property (p_off_hold) else $error("off delay too short");
    property p_none; clk_en && oc_output_func_sel == SEL_NONE
        && oc_output_off_delay == 10'h000 |=> !oc_active; endproperty
    a_none: assert property (p_none) else $error("unassigned output active");
    property p_ry_bound; clk_en && relay_output_func_sel == SEL_ALARM && !relay_active
        && relay_output_on_delay == 10'h002 && $rose(alarm_flag)
        |-> ##[1:RISE_MAX] (relay_active || !alarm_flag); endproperty
    a_ry_bound: assert property (p_ry_bound) else $error("relay on late");
endmodule : dsom_checker
`default_nettype wire

/* File: sim/dsom_mapper_bench.sv */
// Self-checking bench for the status output mapper and its monitored load.
// Assumes TICK_LEN shortened to 4 so one delay step is four clocks.
`timescale 1ns/1ps
`default_nettype none
module dsom_mapper_bench;
    import dsom_pkg::*;
    localparam logic [7:0] CODES [27] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h09, 8'h11, 8'h12, 8'h13, 8'h21, 8'h27, 8'h31, 8'h32, 8'h33, 8'h41, 8'h42, 8'h43,
        8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h58, 8'h59, 8'h60};
    logic        clk = 1'b0, nrst = 1'b0, en = 1'b1;
    logic [26:0] st = '0;
    logic [7:0]  s_oc = SEL_NONE, s_ry = SEL_NONE;
    logic [1:0]  p_oc = POL_NORM_CLOSED, p_ry = POL_NORM_CLOSED;
    logic [9:0]  on_oc = '0, off_oc = '0, on_ry = '0, off_ry = '0;
    logic        cl, ra, rb, act, ract, lamp, trip;
    int          n_errors = 0, n_compared = 0, n;

    always #25 clk = ~clk;
    dsom_mapper #(.TICK_LEN(4)) i_dsom_mapper (.clk(clk), .nrst(nrst), .clk_en(en),
        .motor_running(st[0]), .speed_constant_reached(st[1]), .freq_overreached(st[2]),
        .overload_advance_warn(st[3]), .loop_output_deviation(st[4]), .alarm_flag(st[5]),
        .freq_setpoint_reached(st[6]), .undervoltage_flag(st[7]), .run_time_exceeded(st[8]),
        .power_time_exceeded(st[9]), .thermal_alarm(st[10]), .zero_freq_detect(st[11]),
        .analog_input_lost(st[12]), .feedback_compare(st[13]), .comm_line_lost(st[14]),
        .logic_op_result(st[15]), .start_contact(st[16]), .heatsink_overheat_warn(st[17]),
        .low_current_flag(st[18]), .drive_ready_flag(st[19]), .rotating_forward(st[20]),
        .rotating_reverse(st[21]), .major_failure(st[22]), .analog_window_compare(st[23]),
        .freq_cmd_source(st[24]), .run_cmd_source(st[25]), .second_motor_selected(st[26]),
        .oc_output_func_sel(s_oc), .relay_output_func_sel(s_ry), .oc_output_polarity(p_oc),
        .relay_output_polarity(p_ry), .oc_output_on_delay(on_oc), .oc_output_off_delay(off_oc),
        .relay_output_on_delay(on_ry), .relay_output_off_delay(off_ry),
        .oc_output_closed(cl), .relay_contact_a(ra), .relay_contact_b(rb),
        .oc_active(act), .relay_active(ract));
    dsom_partner i_dsom_partner (.clk(clk), .oc_output_closed(cl), .relay_contact_b(rb),
        .lamp_lit(lamp), .trip_loop_open(trip));

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : cyc
    task automatic chk(input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // Bounded wait; a run-out misses the window and ends the run
    task automatic meas(input bit ry, input logic exp, input int lo, input int hi);
        n = 0;
        while ((ry ? ract : act) !== exp && n < 5000) begin
            cyc(1);
            n++;
        end
        chk(n >= lo && n <= hi, 1'b1);
        if (n >= 5000) final_report();
    endtask : meas

    initial begin
        cyc(12);
        chk(rb, 1'b1);
        chk(ra | cl | act, 1'b0);
        nrst = 1'b1;
        cyc(2);
        for (int i = 0; i < 27; i++) begin
            s_oc = CODES[i];
            s_ry = CODES[i];
            p_oc = 2'(i % 2);
            p_ry = 2'(1 - i % 2);
            st = ~(27'h1 << i);
            cyc(2);
            chk(act | ract, 1'b0);
            chk(cl, p_oc[0]);
            chk(ra, p_ry[0]);
            st = 27'h1 << i;
            cyc(2);
            chk(act & ract, 1'b1);
            chk(cl, !p_oc[0]);
            chk(rb, p_ry[0]);
        end
        cyc(1);
        chk(lamp, 1'b1);
        chk(trip, 1'b0);
        st = '1;
        s_oc = SEL_NONE;
        cyc(2);
        chk(act, 1'b0);
        st = '0;
        s_oc = SEL_RUNNING;
        on_oc = 10'h003;
        off_oc = 10'h003;
        cyc(2);
        st[0] = 1'b1;
        cyc(5);
        st[0] = 1'b0;
        cyc(20);
        chk(act, 1'b0);
        st[0] = 1'b1;
        meas(1'b0, 1'b1, 9, 13);
        st[0] = 1'b0;
        cyc(3);
        st[0] = 1'b1;
        cyc(12);
        chk(act, 1'b1);
        st[0] = 1'b0;
        meas(1'b0, 1'b0, 9, 13);
        en = 1'b0;
        on_oc = '0;
        st[0] = 1'b1;
        cyc(4);
        chk(act, 1'b0);
        en = 1'b1;
        meas(1'b0, 1'b1, 1, 1);
        // Unlisted polarity codes behave as normally open
        p_oc = 2'h3;
        cyc(1);
        chk(cl, 1'b1);
        s_ry = SEL_ALARM;
        on_ry = 10'h002;
        cyc(2);
        st[5] = 1'b1;
        meas(1'b1, 1'b1, 5, 9);
        st[5] = 1'b0;
        on_ry = DELAY_MAX;
        cyc(2);
        chk(ract, 1'b0);
        st[5] = 1'b1;
        meas(1'b1, 1'b1, 3997, 4001);
        off_ry = 10'h002;
        st[5] = 1'b0;
        meas(1'b1, 1'b0, 5, 9);
        // Mid-run reset returns the relay to its power-off pairs
        nrst = 1'b0;
        cyc(1);
        chk(rb & !ra & !act & !ract, 1'b1);
        nrst = 1'b1;
        cyc(2);
        chk(act, 1'b1);
        chk(rb, !ra);
        final_report();
    end
endmodule : dsom_mapper_bench

bind dsom_mapper dsom_checker #(.TICK_LEN(TICK_LEN)) i_dsom_checker (.clk(clk), .nrst(nrst),
    .clk_en(clk_en), .motor_running(motor_running), .alarm_flag(alarm_flag),
    .oc_output_func_sel(oc_output_func_sel), .relay_output_func_sel(relay_output_func_sel),
    .oc_output_polarity(oc_output_polarity), .relay_output_polarity(relay_output_polarity),
    .oc_output_on_delay(oc_output_on_delay), .oc_output_off_delay(oc_output_off_delay),
    .relay_output_on_delay(relay_output_on_delay), .oc_output_closed(oc_output_closed),
    .relay_contact_a(relay_contact_a), .relay_contact_b(relay_contact_b),
    .oc_active(oc_active), .relay_active(relay_active));
`default_nettype wire

/* File: sim/dsom_partner.sv */
// Monitored equipment: a lamp on the open collector, a trip loop on relay pair b.
// Assumes contact levels from the mapper, 1 meaning closed.
`timescale 1ns/1ps
`default_nettype none
module dsom_partner (
    input  wire logic clk,
    input  wire logic oc_output_closed,
    input  wire logic relay_contact_b,
    output logic      lamp_lit,
    output logic      trip_loop_open
);
    always_ff @(posedge clk) begin
        lamp_lit       <= oc_output_closed;
        trip_loop_open <= !relay_contact_b;
    end
endmodule : dsom_partner
`default_nettype wire
